// ===== design/sae_ctrl.sv
`timescale 1ns/10ps
// Operation
// - Disabled set ignores its activation factor
// - Reset leaves all four sets disabled
// - Disable command mask disables selected sets
// - Enable command mask enables selected sets
// - Activation command fires selected sets together
// - Unselected sets keep state, fire only on own compare factor
// - Disable by command, error, or one-shot
// - Readback low nibble shows enable state
// - Interrupt enable bits gate activation interrupts
// - Compare to action takes two clocks
// - Codes select compare trigger, pulse action
// - Pin mode three drives sync pulse
// - Width code seven gives longest pulse
// - Latched error blocks enables until cleared
// - Repeat flag keeps set enabled after firing
module sae_ctrl
  import sae_pkg::*;
#(
  parameter int PULSE_CYC_P = PULSE_CYC, // Widest pulse, cycles
  parameter int CNT_W       = 18         // Pulse counter width
) (
  input  wire logic              mclk,            // 250 MHz clock
  input  wire logic              sys_rst,         // Async reset, high
  input  wire logic [ADDR_W-1:0] avs_address,     // Byte address
  input  wire logic              avs_read,        // Read request
  input  wire logic              avs_write,       // Write request
  input  wire logic [31:0]       avs_writedata,   // Write data
  input  wire logic [3:0]        avs_byteenable,  // Byte lanes
  output logic      [31:0]       avs_readdata,    // Read data
  output logic                   avs_waitrequest, // Stall
  input  wire logic [3:0]        cmp_true,        // Compare levels
  input  wire logic              error_in,        // Axis error level
  output logic      [3:0]        action_fire,     // Action strobes
  output logic                   sync_irq,        // Activation irq
  output logic                   io_pin_0_o,      // Pin level
  output logic                   io_pin_0_oe_n    // Pin drive, low
);
  // ****************************************
  // Bus handshake
  // ****************************************
  logic        ack_q;     // Answer cycle marker
  logic [31:0] rd_data;   // Read mux output
  logic        next_ack;  // Next answer marker

  // Every access waits exactly one cycle
  assign next_ack        = (avs_read | avs_write) & ~ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  wire do_wr   = avs_write & ack_q;  // Write takes effect here
  wire rd_take = avs_read & ~ack_q;  // Capture read data here

  // Answer marker and registered read data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= next_ack;
      if (rd_take) begin
        avs_readdata <= rd_data;
      end
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  wire sel_cmd   = (avs_address == OFS_CMD);       // Command
  wire sel_param = (avs_address == OFS_PARAM);     // Parameter
  wire sel_inten = (avs_address == OFS_INTEN);     // Irq enables
  wire sel_rb3   = (avs_address == OFS_READBACK3); // Enable state
  wire sel_pio   = (avs_address == OFS_PIO);       // Pin view

  // ****************************************
  // Software registers
  // ****************************************
  logic [15:0] param_low_reg;   // Parameter for set commands
  logic [3:0]  int_enable_reg;  // Irq enable of sets 3..0
  logic [7:0]  command_write_reg; // Last command code
  logic [1:0]  pio_mode_field;  // Pin mode
  logic [2:0]  pulse_width_code;// Pulse width select
  logic        pulse_polarity;  // 0 is positive logic
  logic        error_disables_sets; // Error kills sets
  logic        err_flag;        // Latched error status
  logic        err_q;           // Previous error level
  logic        next_err;        // Next error status

  // Command only counts with the low lane written
  wire       cmd_wr = do_wr & sel_cmd & avs_byteenable[0];
  wire [7:0] code   = avs_writedata[7:0];

  // Error edge and clear command
  wire err_rise = error_in & ~err_q;
  wire err_clr  = cmd_wr & (code == CMD_ERR_CLR);
  wire err_dis  = err_rise & error_disables_sets;

  // A new error wins over a clear in the same cycle
  assign next_err = err_rise | (err_flag & ~err_clr);

  // Enables are refused while the error stands
  wire en_block = error_disables_sets & err_flag;

  // Set masks, zero for other codes
  wire [3:0] en_mask  = cmd_wr ? cmd_mask(code, CMD_ENABLE)   : 4'h0;
  wire [3:0] dis_mask = cmd_wr ? cmd_mask(code, CMD_DISABLE)  : 4'h0;
  wire [3:0] act_mask = cmd_wr ? cmd_mask(code, CMD_ACTIVATE) : 4'h0;

  // Enable gated by error; disable includes error kill
  wire [3:0] en_go  = en_block ? 4'h0 : en_mask;
  wire [3:0] dis_go = dis_mask | {4{err_dis}};

  // Parameter register, per byte lane
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      param_low_reg <= RST_WORD;
    end else if (do_wr && sel_param) begin
      if (avs_byteenable[0]) begin
        param_low_reg[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        param_low_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // Interrupt enables live in byte lane 1 only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      int_enable_reg <= RST_ENABLE;
    end else if (do_wr && sel_inten && avs_byteenable[1]) begin
      int_enable_reg <= avs_writedata[INTEN_LSB+3:INTEN_LSB];
    end
  end

  // Pin settings latch from the parameter at command time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      command_write_reg   <= 8'h00;
      pio_mode_field      <= 2'h0;
      pulse_width_code    <= 3'h0;
      pulse_polarity      <= 1'b0;
      error_disables_sets <= 1'b0;
    end else if (cmd_wr) begin
      command_write_reg <= code;
      if (code == CMD_PIO1) begin
        pio_mode_field <= param_low_reg[1:0];
      end else if (code == CMD_PIO2) begin
        pulse_polarity      <= param_low_reg[POL_BIT];
        pulse_width_code    <= param_low_reg[PW_LSB+2:PW_LSB];
        error_disables_sets <= param_low_reg[ERROR_DISABLES_SETS_BIT];
      end
    end
  end

  // Error status follows the axis error edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      err_q    <= 1'b0;
      err_flag <= 1'b0;
    end else begin
      err_q    <= error_in;
      err_flag <= next_err;
    end
  end

  // ****************************************
  // Action sets
  // ****************************************
  logic [3:0] hit;          // Factor detected per set
  logic [3:0] enable_state; // Enable per set
  logic [3:0] pulse_act;    // Set action is sync pulse

  // Unselected mask bits leave a set alone
  for (genvar m = 0; m < 4; m++) begin : g_set
    sae_slot u_slot (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .cfg_load  (cmd_wr && (code == CMD_SET_CFG0 + 8'(m))),
      .cfg_word  (param_low_reg),
      .en_cmd    (en_go[m]),
      .dis_cmd   (dis_go[m]),
      .act_cmd   (act_mask[m]),
      .cmp_true  (cmp_true[m]),
      .hit       (hit[m]),
      .fire      (action_fire[m]),
      .enabled   (enable_state[m]),
      .pulse_act (pulse_act[m])
    );
  end

  // Interrupt rides on the action strobe
  assign sync_irq = |(action_fire & int_enable_reg);

  // ****************************************
  // Sync pulse output
  // ****************************************
  logic pulse;  // Stretched pulse
  logic pin_q;  // Registered pin level

  wire pin_sync  = (pio_mode_field == PIO_MODE_SYNC);
  wire pls_start = |(action_fire & pulse_act);

  sae_pulse #(
    .CNT_W    (CNT_W),
    .FULL_CYC (PULSE_CYC_P)
  ) u_pulse (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .start      (pls_start),
    .width_code (pulse_width_code),
    .pulse      (pulse)
  );

  // Idle level is the inactive polarity
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_sync ? (pulse ^ pulse_polarity) : 1'b0;
    end
  end

  assign io_pin_0_o    = pin_q;
  // Pin released unless in sync pulse mode
  assign io_pin_0_oe_n = ~pin_sync;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_cmd) begin
      rd_data[7:0] = command_write_reg;
    end else if (sel_param) begin
      rd_data[15:0] = param_low_reg;
    end else if (sel_inten) begin
      rd_data[INTEN_LSB+3:INTEN_LSB] = int_enable_reg;
    end else if (sel_rb3) begin
      rd_data[3:0] = enable_state;
    end else if (sel_pio) begin
      rd_data[9:0] = {err_flag, error_disables_sets, pulse_width_code,
                      pulse_polarity, 2'h0, pio_mode_field};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  wire [3:0] act_sel = act_mask & enable_state;

  a_reset_all_off:
    assert property ($fell(sys_rst) |-> enable_state == 4'h0)
    else $error("set enabled after reset");

  a_disable_mask:
    assert property (|dis_mask |=> (enable_state & $past(dis_mask)) == 4'h0)
    else $error("disable command left a set on");

  a_enable_mask:
    assert property (|en_mask && !en_block && !err_dis |=>
                     (enable_state & $past(en_mask)) == $past(en_mask))
    else $error("enable command missed a set");

  a_unselected_keep:
    assert property (cmd_wr && !err_dis && hit == 4'h0 |=>
                     ((enable_state ^ $past(enable_state)) &
                      ~$past(en_go | dis_go)) == 4'h0)
    else $error("unselected set changed state");

  a_activate_two:
    assert property (|act_sel |-> ##2
                     (action_fire & $past(act_sel, 2)) == $past(act_sel, 2))
    else $error("activation did not fire in two clocks");

  a_off_never_fires:
    assert property (|action_fire |->
                     (action_fire & ~$past(enable_state, 2)) == 4'h0)
    else $error("disabled set fired");

  a_error_kills:
    assert property (err_dis |=> enable_state == 4'h0)
    else $error("error left a set enabled");

  a_error_blocks:
    assert property (en_block && !err_clr |=>
                     (enable_state & ~$past(enable_state)) == 4'h0)
    else $error("enable accepted during error");

  a_irq_cause:
    assert property (sync_irq |-> $past(|(hit & int_enable_reg)))
    else $error("interrupt without activation");

  a_pin_pulse:
    assert property (pin_sync && pls_start && $stable(pio_mode_field) |-> ##2
                     (io_pin_0_o != pulse_polarity))
    else $error("sync pulse missing on pin");

  a_readback:
    assert property (avs_read && !avs_waitrequest && sel_rb3 |->
                     avs_readdata[3:0] == $past(enable_state))
    else $error("readback differs from enable state");

  c_enable_then_fire:
    cover property (|en_go ##[1:20] |action_fire);

  c_error_kill:
    cover property (err_dis && enable_state != 4'h0);

  c_pin_pulse:
    cover property (pin_sync && pls_start);

  c_enable_vs_oneshot:
    cover property (|(en_go & hit));
endmodule

// ===== design/sae_pkg.sv
package sae_pkg;
  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam int         ADDR_W        = 5;
  localparam logic [4:0] OFS_CMD       = 5'h00; // Command write
  localparam logic [4:0] OFS_PARAM     = 5'h04; // Parameter word
  localparam logic [4:0] OFS_INTEN     = 5'h08; // Interrupt enables
  localparam logic [4:0] OFS_READBACK3 = 5'h0C; // Set enable state
  localparam logic [4:0] OFS_PIO       = 5'h10; // Pin and error view
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_ENABLE    = 8'h80; // Plus set mask
  localparam logic [7:0] CMD_DISABLE   = 8'h90; // Plus set mask
  localparam logic [7:0] CMD_ACTIVATE  = 8'hA0; // Plus set mask
  localparam logic [7:0] CMD_ERR_CLR   = 8'h79; // Error status clear
  localparam logic [7:0] CMD_PIO1      = 8'h21; // Pin mode setting
  localparam logic [7:0] CMD_PIO2      = 8'h22; // Pulse and error setting
  localparam logic [7:0] CMD_SET_CFG0  = 8'h26; // Set 0 config, +m
  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int         POL_BIT       = 0;     // pulse_polarity
  localparam int         PW_LSB        = 4;     // pulse_width_code
  localparam int         ERROR_DISABLES_SETS_BIT     = 7;     // error_disables_sets
  localparam int         ACT_LSB       = 4;     // action_code
  localparam int         REP_BIT       = 15;    // repeat_flag
  localparam int         INTEN_LSB     = 12;    // Set interrupt bits
  localparam logic [1:0] PIO_MODE_SYNC = 2'h3;  // Sync pulse on pin
  localparam logic [3:0] TRIG_CMP      = 4'h1;  // Compare became true
  localparam logic [4:0] ACT_SYNC_PLS  = 5'h09; // Sync pulse action
  localparam logic [2:0] PW_MAX        = 3'h7;  // Code of 1 ms
  localparam logic [3:0] RST_ENABLE    = 4'h0;  // All set interrupts disabled
  localparam logic [15:0] RST_WORD     = 16'h0000;
  // ****************************************
  // Timing
  // ****************************************
  localparam int         PULSE_TIME_US = 1000;  // Longest pulse, us
  localparam int         CLK_MHZ       = 250;   // mclk rate
  localparam int         PULSE_CYC     = PULSE_TIME_US * CLK_MHZ;

  // Set mask of a command if it lies in the range of base
  function automatic logic [3:0] cmd_mask(input logic [7:0] code,
                                          input logic [7:0] base);
    cmd_mask = (code[7:4] == base[7:4]) ? code[3:0] : 4'h0;
  endfunction
endpackage

// ===== design/sae_slot.sv
`timescale 1ns/10ps
module sae_slot
  import sae_pkg::*;
(
  input  wire logic        mclk,      // System clock
  input  wire logic        sys_rst,   // Async reset, high
  input  wire logic        cfg_load,  // Load set configuration
  input  wire logic [15:0] cfg_word,  // Configuration word
  input  wire logic        en_cmd,    // Enable this set
  input  wire logic        dis_cmd,   // Disable this set
  input  wire logic        act_cmd,   // Activate by command
  input  wire logic        cmp_true,  // Compare condition level
  output logic             hit,       // Factor detected
  output logic             fire,      // Action strobe
  output logic             enabled,   // Enable state
  output logic             pulse_act  // Action is sync pulse
);
  logic [3:0] trig;   // trigger_code
  logic [4:0] act;    // action_code
  logic       repeat_flag;    // repeat_flag
  logic       cmp_q;  // Previous compare level
  logic       next_en;

  // Compare factor fires on the false to true change only
  wire factor   = (trig == TRIG_CMP) & cmp_true & ~cmp_q;
  wire next_hit = enabled & (factor | act_cmd);
  assign pulse_act = (act == ACT_SYNC_PLS);

  // Disable beats enable; an enable beats one-shot completion
  always_comb begin
    next_en = enabled;
    if (dis_cmd) begin
      next_en = 1'b0;
    end else if (en_cmd) begin
      next_en = 1'b1;
    end else if (hit && !repeat_flag) begin
      next_en = 1'b0;
    end
  end

  // One clock to detect, one to act
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {trig, act, repeat_flag} <= '0;
      cmp_q   <= 1'b0;
      hit     <= 1'b0;
      fire    <= 1'b0;
      enabled <= 1'b0;
    end else begin
      if (cfg_load) begin
        trig <= cfg_word[ACT_LSB-1:0];
        act  <= cfg_word[ACT_LSB+4:ACT_LSB];
        repeat_flag  <= cfg_word[REP_BIT];
      end
      cmp_q   <= cmp_true;
      hit     <= next_hit;
      fire    <= hit;
      enabled <= next_en;
    end
  end
endmodule

// ===== design/sae_pulse.sv
`timescale 1ns/10ps
module sae_pulse
  import sae_pkg::*;
#(
  parameter int CNT_W    = 18,       // Counter width
  parameter int FULL_CYC = PULSE_CYC // Cycles of the widest pulse
) (
  input  wire logic       mclk,       // System clock
  input  wire logic       sys_rst,    // Async reset, high
  input  wire logic       start,      // Start or retrigger
  input  wire logic [2:0] width_code, // pulse_width_code
  output logic            pulse       // High while running
);
  logic [CNT_W-1:0] cnt; // Remaining cycles

  // Each lower code halves the width
  wire [CNT_W-1:0] load_val = CNT_W'(FULL_CYC) >> (PW_MAX - width_code);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= load_val;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign pulse = (cnt != '0);
endmodule

// ===== sim/sae_host.sv
`timescale 1ns/10ps
// ****************************************
// Host processor model: bus master
// ****************************************
module sae_host
  import sae_pkg::*;
(
  input  wire logic              mclk,            // System clock
  output logic      [ADDR_W-1:0] avs_address,     // Byte address
  output logic                   avs_read,        // Read request
  output logic                   avs_write,       // Write request
  output logic      [31:0]       avs_writedata,   // Write data
  output logic      [3:0]        avs_byteenable,  // Byte lanes
  input  wire logic [31:0]       avs_readdata,    // Read data
  input  wire logic              avs_waitrequest, // Stall
  output logic                   hung             // A wait ran out
);
  // Bus idle from time zero
  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    hung           = 1'b0;
  end

  // One transfer, held until waitrequest is seen low
  task automatic xfer(input logic              is_wr,
                      input logic [ADDR_W-1:0] a,
                      input logic [15:0]       d,
                      output logic [31:0]      q);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= is_wr;
    avs_read      <= ~is_wr;
    n = 0;
    // Sampled at the rising edge, before that edge's own updates land
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    hung <= hung | (n >= 40);
    // Read data stand at the same edge that ends the wait
    q = avs_readdata;
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    // Stale data must not look valid once released
    avs_writedata <= ~avs_writedata;
  endtask
endmodule

// ===== sim/sae_ctrl_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("BAD at %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
// ****************************************
// Bench for the sync action set control
// ****************************************
module sae_ctrl_bench
  import sae_pkg::*;
;
  logic              mclk;        // 250 MHz clock
  logic              sys_rst;     // Reset, high
  logic [ADDR_W-1:0] address;     // Bus address
  logic              read;        // Bus read
  logic              write;       // Bus write
  logic [31:0]       wdata;       // Bus write data
  logic [3:0]        ben;         // Bus lanes
  logic [31:0]       rdata;       // Bus read data
  logic              wait_req;    // Bus stall
  logic [3:0]        cmp_true;    // Compare levels
  logic              error_in;    // Axis error
  logic [3:0]        action_fire; // Action strobes
  logic              sync_irq;    // Interrupt
  logic              pin_o;       // Pin level
  logic              pin_oe_n;    // Pin drive, low
  logic              hung;        // Host wait ran out
  int                err_total;   // Mismatches
  int                checked;     // Comparisons

  // Short pulse count keeps the run brief
  sae_ctrl #(.PULSE_CYC_P(64), .CNT_W(18)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(address), .avs_read(read),
    .avs_write(write), .avs_writedata(wdata), .avs_byteenable(ben),
    .avs_readdata(rdata), .avs_waitrequest(wait_req), .cmp_true(cmp_true),
    .error_in(error_in), .action_fire(action_fire), .sync_irq(sync_irq),
    .io_pin_0_o(pin_o), .io_pin_0_oe_n(pin_oe_n)
  );

  sae_host host (
    .mclk(mclk), .avs_address(address), .avs_read(read), .avs_write(write),
    .avs_writedata(wdata), .avs_byteenable(ben), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .hung(hung)
  );

  // Clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test();
    $display("Checks %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A stuck bus ends the run as a failure
  always @(posedge hung) begin
    err_total++;
    stop_test();
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 16'h0000, q);
    `CHK(q, e);
  endtask

  // Command with its parameter word
  task automatic cmd(input logic [7:0] c, input logic [15:0] p);
    wr(OFS_PARAM, p);
    wr(OFS_CMD, {8'h00, c});
  endtask

  // Strobes quiet for k-1 cycles, then the expected ones
  task automatic see(input int k, input logic [3:0] f, input logic irq);
    repeat (k - 1) begin
      @(negedge mclk);
      `CHK(action_fire, 4'h0);
    end
    @(negedge mclk);
    `CHK(action_fire, f);
    `CHK(sync_irq, irq);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int         n;
    logic [3:0] k;
    logic [2:0] w;
    err_total = 0;
    checked   = 0;
    sys_rst   = 1'b1;
    cmp_true  = 4'h0;
    error_in  = 1'b0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_READBACK3, 32'h0000_0000);
    `CHK(pin_oe_n, 1'b1);
    rd(5'h14, 32'h0000_0000);
    // Every nonzero mask, both directions
    for (int m = 1; m < 16; m++) begin
      k = m[3:0];
      wr(OFS_CMD, 16'h009F);
      wr(OFS_CMD, {8'h00, 4'h8, k});
      rd(OFS_READBACK3, {28'h0, k});
      wr(OFS_CMD, 16'h008F);
      wr(OFS_CMD, {8'h00, 4'h9, k});
      rd(OFS_READBACK3, {28'h0, ~k});
    end
    // Set 0 one-shot, others repeat; all compare trigger, pulse action
    for (int s = 0; s < 4; s++) begin
      cmd(CMD_SET_CFG0 + 8'(s), (s == 0) ? 16'h0091 : 16'h8091);
    end
    cmd(CMD_PIO1, 16'h0003);
    // Pin mode lands at the write's own edge; look once it has settled
    @(negedge mclk);
    `CHK(pin_oe_n, 1'b0);
    wr(OFS_CMD, 16'h008F);
    // Compare path, pulse width for two codes
    for (int i = 0; i < 2; i++) begin
      w = (i == 0) ? PW_MAX : 3'h5;
      cmd(CMD_PIO2, {9'h000, w, 4'h0});
      wr(OFS_CMD, 16'h0081);
      @(posedge mclk);
      cmp_true <= 4'h1;
      see(3, 4'h1, 1'b0);
      @(negedge mclk);
      `CHK(pin_o, 1'b0);
      @(negedge mclk);
      `CHK(pin_o, 1'b1);
      // Counts the high cycles of the pin from the first one on
      n = 0;
      while (pin_o === 1'b1 && n < 300) begin
        @(negedge mclk);
        n++;
      end
      `CHK(n, 64 >> (7 - w));
      @(posedge mclk);
      cmp_true <= 4'h0;
      rd(OFS_READBACK3, 32'h0000_000E);
    end
    // Repeat set stays enabled after firing
    @(posedge mclk);
    cmp_true <= 4'h2;
    see(3, 4'h2, 1'b0);
    @(posedge mclk);
    cmp_true <= 4'h0;
    rd(OFS_READBACK3, 32'h0000_000E);
    // Disabled set ignores its factor
    wr(OFS_CMD, 16'h0094);
    @(posedge mclk);
    cmp_true <= 4'h4;
    see(5, 4'h0, 1'b0);
    @(posedge mclk);
    cmp_true <= 4'h0;
    // Activation commands, interrupt gating
    wr(OFS_INTEN, 16'h5000);
    rd(OFS_INTEN, 32'h0000_5000);
    wr(OFS_CMD, 16'h008F);
    wr(OFS_CMD, 16'h00A6);
    see(2, 4'h6, 1'b1);
    wr(OFS_INTEN, 16'h2000);
    wr(OFS_CMD, 16'h0098);
    wr(OFS_CMD, 16'h00AC);
    see(2, 4'h4, 1'b0);
    // Enable lands on the edge that ends a one-shot
    wr(OFS_CMD, 16'h0081);
    fork
      wr(OFS_CMD, 16'h0081);
      begin
        @(posedge mclk);
        cmp_true <= 4'h1;
      end
    join
    @(negedge mclk);
    `CHK(action_fire, 4'h1);
    @(posedge mclk);
    cmp_true <= 4'h0;
    rd(OFS_READBACK3, 32'h0000_0007);
    // Error with error_disables_sets
    cmd(CMD_PIO2, 16'h00F0);
    rd(OFS_PIO, 32'h0000_01E3);
    wr(OFS_CMD, 16'h008F);
    @(posedge mclk);
    error_in <= 1'b1;
    rd(OFS_READBACK3, 32'h0000_0000);
    rd(OFS_PIO, 32'h0000_03E3);
    wr(OFS_CMD, 16'h008F);
    rd(OFS_READBACK3, 32'h0000_0000);
    @(posedge mclk);
    error_in <= 1'b0;
    wr(OFS_CMD, {8'h00, CMD_ERR_CLR});
    wr(OFS_CMD, 16'h008F);
    rd(OFS_READBACK3, 32'h0000_000F);
    stop_test();
  end
endmodule
